// File: design/ext_pin_int_pkg.sv
// Constants, register map and types shared by the external pin interrupt block
package ext_pin_int_pkg;

    // Block geometry
    localparam int unsigned N_EXT = 3;
    localparam int unsigned N_GROUP = 4;
    localparam int unsigned GROUP_W = 8;
    localparam int unsigned N_PC = 32;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // Register indices on the plain register port
    localparam logic [3:0] REG_SENSE = 4'h0;
    localparam logic [3:0] REG_ENABLE = 4'h1;
    localparam logic [3:0] REG_EXT_FLAG = 4'h2;
    localparam logic [3:0] REG_PC_CONTROL = 4'h3;
    localparam logic [3:0] REG_PC_FLAG = 4'h4;
    localparam logic [3:0] REG_PC_MASK0 = 4'h5;
    localparam logic [3:0] REG_PC_MASK3 = 4'h8;

    // Field layout
    localparam int unsigned SENSE_FIELD_W = 6;
    localparam int unsigned SENSE_SEL_W = 2;

    // Reset values
    localparam logic [5:0] SENSE_RESET = 6'h00;
    localparam logic [2:0] ENABLE_RESET = 3'h0;
    localparam logic [3:0] PC_CONTROL_RESET = 4'h0;
    localparam logic [31:0] PC_MASK_RESET = 32'h0000_0000;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Sense selector encodings
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_t;

    // Complete register state of the top module
    typedef struct packed {
        logic [5:0] sense;
        logic [2:0] enable;
        logic [2:0] ext_flag;
        logic [3:0] pc_enable;
        logic [3:0] pc_flag;
        logic [31:0] pc_mask;
        logic [31:0] pc_prev;
        logic pc_primed;
        logic [7:0] rd_data;
    } top_state_t;

    // State of one sense unit
    typedef struct packed {
        logic primed;
        logic prev;
    } unit_state_t;

endpackage

// File: design/ext_sense_if.sv
// Interface joining the top module to one external input sense unit
`timescale 1ns/100ps
`default_nettype none
interface ext_sense_if;
    import ext_pin_int_pkg::*;
    logic pin;
    sense_t sense;
    logic active;
    logic armed;
    logic trigger;
    logic level_low;
    modport unit (input pin, input sense, input active, output armed, output trigger, output level_low);
    modport ctrl (output pin, output sense, output active, input armed, input trigger, input level_low);
endinterface
`default_nettype wire

// File: design/ext_sense_unit.sv
// Sense unit: edge and level detection for one external interrupt input
`timescale 1ns/100ps
`default_nettype none
module ext_sense_unit (
    input wire logic clock,
    input wire logic rst_n,
    ext_sense_if.unit port
);
    import ext_pin_int_pkg::*;

    unit_state_t s;
    unit_state_t next_s;
    logic rise;
    logic fall;

    // Edges are seen against the last level taken while the clock ran
    assign rise = s.primed & port.pin & ~s.prev;
    assign fall = s.primed & ~port.pin & s.prev;
    assign port.level_low = ~port.pin;

    always_comb begin
        case (port.sense)
            SENSE_ANY: port.armed = rise | fall;
            SENSE_FALL: port.armed = fall;
            SENSE_RISE: port.armed = rise;
            default: port.armed = 1'b0;
        endcase
    end

    // pending edge is held, only reported while running
    assign port.trigger = port.armed & port.active;

    // Reference level freezes while the I/O clock is stopped
    always_comb begin
        next_s = s;
        if (port.active) begin
            next_s.prev = port.pin;
            next_s.primed = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    chk_fall_trigger: assert property (
        (port.active && port.sense == SENSE_FALL && s.primed && s.prev && !port.pin) |-> port.trigger)
        else $error("falling edge did not trigger");

    chk_stopped_silent: assert property (
        !port.active |-> !port.trigger)
        else $error("trigger while I/O clock stopped");

endmodule
`default_nettype wire

// File: design/external_pin_interrupts.sv
// External pin and pin-change interrupt controller with its registers
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ext_pin_int_pkg::ADDR_W-1:0] addr,
    input wire logic [ext_pin_int_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [ext_pin_int_pkg::DATA_W-1:0] rd_data,
    input wire logic [ext_pin_int_pkg::N_EXT-1:0] ext_irq_pins,
    input wire logic [ext_pin_int_pkg::N_PC-1:0] pin_change_inputs,
    input wire logic global_int_enable,
    input wire logic io_clk_active,
    input wire logic [ext_pin_int_pkg::N_EXT-1:0] ext_irq_ack,
    input wire logic [ext_pin_int_pkg::N_GROUP-1:0] pin_change_ack,
    output logic [ext_pin_int_pkg::N_EXT-1:0] ext_irq_request,
    output logic [ext_pin_int_pkg::N_GROUP-1:0] pin_change_group_request,
    output logic wake_request
);
    import ext_pin_int_pkg::*;

    top_state_t s;
    top_state_t next_s;

    logic [N_EXT-1:0] ext_trigger;
    logic [N_EXT-1:0] ext_armed;
    logic [N_EXT-1:0] ext_low;
    logic [N_EXT-1:0] ext_level_mode;
    logic [N_PC-1:0] pc_diff;
    logic [N_GROUP-1:0] pc_group_diff;
    logic [N_GROUP-1:0] pc_group_hit;

    // True when a selector pair asks for level sensing
    function automatic logic is_level(input logic [5:0] sense, input int unsigned n);
        is_level = (sense[SENSE_SEL_W*n +: SENSE_SEL_W] == SENSE_LOW);
    endfunction

    // Reduce a 32-bit vector into one bit per group of eight
    function automatic logic [3:0] group_any(input logic [31:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int g = 0; g < N_GROUP; g++) begin
            r[g] = |v[GROUP_W*g +: GROUP_W];
        end
        group_any = r;
    endfunction

    // True when a register write hits the given index
    function automatic logic write_hit(input logic we, input logic [3:0] a, input logic [3:0] idx);
        write_hit = we && (a == idx);
    endfunction

    ext_sense_if ext_if[N_EXT] ();

    // One sense unit per external input
    // pins are read as levels, whatever drives them
    generate
        for (genvar n = 0; n < N_EXT; n++) begin : g_ext
            assign ext_if[n].pin = ext_irq_pins[n];
            assign ext_if[n].sense = sense_t'(s.sense[SENSE_SEL_W*n +: SENSE_SEL_W]);
            assign ext_if[n].active = io_clk_active;
            assign ext_trigger[n] = ext_if[n].trigger;
            assign ext_armed[n] = ext_if[n].armed;
            assign ext_low[n] = ext_if[n].level_low;
            assign ext_level_mode[n] = is_level(s.sense, n);
            ext_sense_unit u_unit (
                .clock(clock),
                .rst_n(rst_n),
                .port(ext_if[n])
            );
        end
    endgenerate

    // Pin-change detection against the last level seen with the clock running
    // the per-pin mask gates each contribution
    assign pc_diff = (pin_change_inputs ^ s.pc_prev) & s.pc_mask & {N_PC{s.pc_primed}};
    // group 3 takes 31:24 down to group 0 on 7:0
    assign pc_group_diff = group_any(pc_diff);
    // flags only set while the I/O clock runs
    assign pc_group_hit = pc_group_diff & {N_GROUP{io_clk_active}};

    // Next-state logic for registers and flags
    always_comb begin
        next_s = s;
        next_s.rd_data = READ_IDLE;

        // Software writes to control registers
        if (wr_en) begin
            case (addr)
                // three selector pairs in the low six bits
                REG_SENSE: next_s.sense = wr_data[SENSE_FIELD_W-1:0];
                REG_ENABLE: next_s.enable = wr_data[N_EXT-1:0];
                REG_PC_CONTROL: next_s.pc_enable = wr_data[N_GROUP-1:0];
                default: begin
                    if (addr >= REG_PC_MASK0 && addr <= REG_PC_MASK3) begin
                        next_s.pc_mask[GROUP_W*(addr - REG_PC_MASK0) +: GROUP_W] = wr_data;
                    end
                end
            endcase
        end

        // external flags: a trigger outranks a clear in the same cycle
        for (int n = 0; n < N_EXT; n++) begin
            if (is_level(next_s.sense, n)) begin
                next_s.ext_flag[n] = 1'b0;
            end else if (ext_trigger[n]) begin
                next_s.ext_flag[n] = 1'b1;
            end else if (ext_irq_ack[n] || (write_hit(wr_en, addr, REG_EXT_FLAG) && wr_data[n])) begin
                next_s.ext_flag[n] = 1'b0;
            end
        end

        // group flags: a change outranks a clear in the same cycle
        for (int g = 0; g < N_GROUP; g++) begin
            if (pc_group_hit[g]) begin
                next_s.pc_flag[g] = 1'b1;
            end else if (pin_change_ack[g] || (write_hit(wr_en, addr, REG_PC_FLAG) && wr_data[g])) begin
                next_s.pc_flag[g] = 1'b0;
            end
        end

        // reference level freezes while stopped, so a pin that returns leaves no change
        if (io_clk_active) begin
            next_s.pc_prev = pin_change_inputs;
            next_s.pc_primed = 1'b1;
        end

        // Read data for the following cycle only
        if (rd_en) begin
            case (addr)
                // top two bits of the sense register read zero
                REG_SENSE: next_s.rd_data = {2'h0, s.sense};
                REG_ENABLE: next_s.rd_data = {5'h00, s.enable};
                REG_EXT_FLAG: next_s.rd_data = {5'h00, s.ext_flag};
                REG_PC_CONTROL: next_s.rd_data = {4'h0, s.pc_enable};
                REG_PC_FLAG: next_s.rd_data = {4'h0, s.pc_flag};
                default: begin
                    if (addr >= REG_PC_MASK0 && addr <= REG_PC_MASK3) begin
                        next_s.rd_data = s.pc_mask[GROUP_W*(addr - REG_PC_MASK0) +: GROUP_W];
                    end
                end
            endcase
        end
    end

    // State register; flags and controls come up cleared
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s.sense <= SENSE_RESET;
            s.enable <= ENABLE_RESET;
            s.ext_flag <= 3'h0;
            s.pc_enable <= PC_CONTROL_RESET;
            s.pc_flag <= 4'h0;
            s.pc_mask <= PC_MASK_RESET;
            s.pc_prev <= 32'h0000_0000;
            s.pc_primed <= 1'b0;
            s.rd_data <= READ_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;

    // Requests to the core
    // global enable and per-input mask must both be set
    // level mode requests straight from the pin while it stays low and the I/O clock runs
    // a level gone before the clock returns leaves no request
    always_comb begin
        for (int n = 0; n < N_EXT; n++) begin
            ext_irq_request[n] = global_int_enable && s.enable[n] &&
                (ext_level_mode[n] ? (ext_low[n] && io_clk_active) : s.ext_flag[n]);
        end
    end

    // group request needs its flag, its enable and the global enable
    assign pin_change_group_request = s.pc_flag & s.pc_enable & {N_GROUP{global_int_enable}};

    // pin-change wake is combinational, so it works with the clock stopped
    // enabled low levels and held edges also wake; no core enable needed for wake
    assign wake_request = !io_clk_active &&
        (|(pc_group_diff & s.pc_enable) ||
         |(s.enable & ext_level_mode & ext_low) ||
         |(s.enable & ~ext_level_mode & ext_armed));

    // inputs arrive synchronous, so every flag update is a clean clocked event

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Trigger and clear meeting in one cycle
    sequence seq_trig_and_ack0;
        ext_trigger[0] && ext_irq_ack[0] && !is_level(next_s.sense, 0);
    endsequence

    // Masked change on group 0 while running and primed
    sequence seq_pc0_change;
        io_clk_active && s.pc_primed && |((pin_change_inputs ^ s.pc_prev) & s.pc_mask & 32'h0000_00FF);
    endsequence

    chk_flag_set_wins: assert property (
        seq_trig_and_ack0 |=> s.ext_flag[0])
        else $error("clear beat a simultaneous trigger");

    chk_level_flag_zero: assert property (
        is_level(s.sense, 1) |-> !s.ext_flag[1])
        else $error("flag set in level mode");

    chk_level_request: assert property (
        (is_level(s.sense, 0) && s.enable[0] && global_int_enable && io_clk_active && !ext_irq_pins[0])[*2]
        |-> ext_irq_request[0])
        else $error("held low level lost its request");

    chk_pc_group_flag: assert property (
        seq_pc0_change |=> s.pc_flag[0] ##1 (s.pc_flag[0] || $past(pin_change_ack[0]) || $past(wr_en)))
        else $error("pin change did not set group flag");

    chk_pc_gated_clock: assert property (
        !io_clk_active |=> ((s.pc_flag & ~$past(s.pc_flag)) == 4'h0))
        else $error("group flag set while clock stopped");

    chk_sense_reserved: assert property (
        (rd_en && addr == REG_SENSE) |=> (rd_data[7:6] == 2'h0) ##1 (rd_data == READ_IDLE || $past(rd_en)))
        else $error("sense reserved bits not zero");

    chk_ext_req_gate: assert property (
        ext_irq_request[2] |-> (global_int_enable && s.enable[2]))
        else $error("request without enables");

    chk_pc_req_gate: assert property (
        |pin_change_group_request |-> (global_int_enable && |(s.pc_flag & s.pc_enable)))
        else $error("group request without flag and enable");

    chk_wake_level: assert property (
        (!io_clk_active && s.enable[0] && is_level(s.sense, 0) && !ext_irq_pins[0]) |-> wake_request)
        else $error("low level did not request wake");

    chk_pc_return_quiet: assert property (
        (io_clk_active && (pin_change_inputs == s.pc_prev)) |=> ((s.pc_flag & ~$past(s.pc_flag)) == 4'h0))
        else $error("group flag set with no net change");

    // wake is only asked for while the I/O clock is stopped
    chk_wake_idle: assert property (
        io_clk_active |-> !wake_request)
        else $error("wake request while clock runs");

    // an enabled group change during sleep must wake the part
    chk_wake_pc: assert property (
        (!io_clk_active && |(pc_group_diff & s.pc_enable)) |-> wake_request)
        else $error("group change did not request wake");

    // a held edge on an enabled input wakes as well
    chk_wake_edge: assert property (
        (!io_clk_active && s.enable[1] && !is_level(s.sense, 1) && ext_armed[1]) |-> wake_request)
        else $error("held edge did not request wake");

    // no level request reaches the core while the clock is stopped
    chk_level_stopped: assert property (
        (!io_clk_active && is_level(s.sense, 0)) |-> !ext_irq_request[0])
        else $error("level request while clock stopped");

    // read data stand one cycle only, then idle
    chk_read_idle: assert property (
        !rd_en |=> (rd_data == READ_IDLE))
        else $error("read data outside its cycle");

    // a sense write lands in the low six bits only
    chk_sense_write: assert property (
        (wr_en && addr == REG_SENSE) |=> ({2'h0, s.sense} == ($past(wr_data) & 8'h3F)))
        else $error("sense write did not land");

    // an enable write lands in the three mask bits
    chk_enable_write: assert property (
        (wr_en && addr == REG_ENABLE) |=> ({5'h00, s.enable} == ($past(wr_data) & 8'h07)))
        else $error("enable write did not land");

    // input zero also needs both enables
    chk_ext_req_gate0: assert property (
        ext_irq_request[0] |-> (global_int_enable && s.enable[0]))
        else $error("request zero without enables");

    // an edge trigger sets the flag in the next cycle
    chk_ext_trig_set: assert property (
        (ext_trigger[2] && !is_level(next_s.sense, 2)) |=> s.ext_flag[2])
        else $error("edge trigger did not set flag");

    // handler entry clears the flag when no trigger competes
    chk_ext_ack_clear: assert property (
        (ext_irq_ack[1] && !ext_trigger[1]) |=> !s.ext_flag[1])
        else $error("handler entry did not clear flag");

    // a written one clears the flag when no trigger competes
    chk_ext_wr_clear: assert property (
        (write_hit(wr_en, addr, REG_EXT_FLAG) && wr_data[0] && !ext_trigger[0]) |=> !s.ext_flag[0])
        else $error("written one did not clear flag");

    // group enable write lands in the four low bits
    chk_pc_enable_write: assert property (
        (wr_en && addr == REG_PC_CONTROL) |=> ({4'h0, s.pc_enable} == ($past(wr_data) & 8'h0F)))
        else $error("group enable write did not land");

    // handler entry clears a group flag when no change competes
    chk_pc_ack_clear: assert property (
        (pin_change_ack[3] && !pc_group_hit[3]) |=> !s.pc_flag[3])
        else $error("group entry did not clear flag");

    // a written one clears a group flag when no change competes
    chk_pc_wr_clear: assert property (
        (write_hit(wr_en, addr, REG_PC_FLAG) && wr_data[1] && !pc_group_hit[1]) |=> !s.pc_flag[1])
        else $error("written one did not clear group flag");

    // flag, group enable and global enable together give the request
    chk_pc_req_given: assert property (
        (s.pc_flag[2] && s.pc_enable[2] && global_int_enable) |-> pin_change_group_request[2])
        else $error("enabled group flag gave no request");

    // a mask write to group zero lands in its low byte
    chk_mask_write: assert property (
        (wr_en && addr == REG_PC_MASK0) |=> (s.pc_mask[7:0] == $past(wr_data)))
        else $error("mask write did not land");

    // changes on masked pins never set the group flag
    chk_pc_masked_quiet: assert property (
        (((pin_change_inputs ^ s.pc_prev) & s.pc_mask & 32'hFF00_0000) == 32'h0000_0000)
        |=> (!s.pc_flag[3] || $past(s.pc_flag[3])))
        else $error("masked change set group flag");

endmodule
`default_nettype wire

// File: tb/pin_source.sv
// Board-side model that drives the external and pin-change input pins
`timescale 1ns/100ps
`default_nettype none
module pin_source (
    input wire logic clock,
    input wire logic [2:0] ext_cmd,
    input wire logic [31:0] pc_cmd,
    output logic [2:0] ext_irq_pins,
    output logic [31:0] pin_change_inputs
);
    // hold commanded level
    // Each level stands until the next command, so a low level outlasts the current instruction
    always_ff @(posedge clock) begin
        ext_irq_pins <= ext_cmd;
        pin_change_inputs <= pc_cmd;
    end
endmodule
`default_nettype wire

// File: tb/external_pin_interrupts_bench.sv
// Self-checking bench for the external pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupts_bench;
    import ext_pin_int_pkg::*;
    typedef struct packed {sense_t mode; logic to; logic req; logic flag;} row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic global_int_enable = 1'b1;
    logic io_clk_active = 1'b1;
    logic [2:0] ext_irq_ack = 3'h0;
    logic [3:0] pin_change_ack = 4'h0;
    logic [2:0] ext_cmd = 3'h7;
    logic [31:0] pc_cmd = 32'h0000_0000;
    logic [31:0] pcv = 32'h0000_0000;
    logic [7:0] rd_data;
    logic [2:0] ext_irq_pins;
    logic [31:0] pin_change_inputs;
    logic [2:0] ext_irq_request;
    logic [3:0] pin_change_group_request;
    logic wake_request;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    // One row per sense mode and edge direction: mode, final level, request, flag
    row_t rows [8] = '{'{SENSE_ANY, 1'b1, 1'b1, 1'b1}, '{SENSE_ANY, 1'b0, 1'b1, 1'b1},
        '{SENSE_FALL, 1'b0, 1'b1, 1'b1}, '{SENSE_FALL, 1'b1, 1'b0, 1'b0},
        '{SENSE_RISE, 1'b1, 1'b1, 1'b1}, '{SENSE_RISE, 1'b0, 1'b0, 1'b0},
        '{SENSE_LOW, 1'b0, 1'b1, 1'b0}, '{SENSE_LOW, 1'b1, 1'b0, 1'b0}};

    // 10 MHz clock
    always #50 clock = ~clock;

    pin_source u_pins (.clock(clock), .ext_cmd(ext_cmd), .pc_cmd(pc_cmd), .ext_irq_pins(ext_irq_pins),
        .pin_change_inputs(pin_change_inputs));

    external_pin_interrupts u_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_irq_pins(ext_irq_pins),
        .pin_change_inputs(pin_change_inputs), .global_int_enable(global_int_enable),
        .io_clk_active(io_clk_active), .ext_irq_ack(ext_irq_ack), .pin_change_ack(pin_change_ack),
        .ext_irq_request(ext_irq_request), .pin_change_group_request(pin_change_group_request),
        .wake_request(wake_request));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Four-state compare, so an unknown never counts as a match
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there
    task automatic rd(logic [3:0] a, logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(negedge clock);
        check(32'(rd_data), 32'(e));
    endtask

    // New pin levels reach the block one edge after the command
    task automatic pins(logic [2:0] e, logic [31:0] p);
        @(posedge clock);
        ext_cmd <= e;
        pc_cmd <= p;
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic settle;
        @(posedge clock);
        @(negedge clock);
    endtask

    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            test_done;
        end
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, the unmapped index, and the unused sense bits
        for (int i = 0; i < 10; i++) begin
            rd(4'(i), 8'h00);
        end
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        wr(REG_SENSE, 8'hFF);
        rd(REG_SENSE, 8'h3F);
        // Every sense mode on every external input
        for (int n = 0; n < 3; n++) begin
            foreach (rows[r]) begin
                // disable, set sense, clear flag, enable
                wr(REG_ENABLE, 8'h00);
                wr(REG_SENSE, 8'(32'(rows[r].mode) << (2 * n)));
                pins(3'h7 ^ 3'(!rows[r].to ? 0 : 1 << n), pcv);
                wr(REG_EXT_FLAG, 8'hFF);
                wr(REG_ENABLE, 8'(1 << n));
                pins(3'h7 ^ 3'(rows[r].to ? 0 : 1 << n), pcv);
                settle;
                check(32'(ext_irq_request), 32'(rows[r].req) << n);
                rd(REG_EXT_FLAG, 8'(32'(rows[r].flag) << n));
                check(32'(ext_irq_request), 32'(rows[r].req) << n);
                @(posedge clock) ext_irq_ack <= 3'(1 << n);
                @(posedge clock) ext_irq_ack <= 3'h0;
                @(negedge clock);
                check(32'(ext_irq_request), 32'(rows[r].req && rows[r].mode == SENSE_LOW) << n);
            end
        end
        // Global enable gates the external request
        @(posedge clock) global_int_enable <= 1'b0;
        @(negedge clock);
        check(32'(ext_irq_request), 32'h0);
        @(posedge clock) global_int_enable <= 1'b1;
        // Low level during sleep wakes but raises nothing once gone
        wr(REG_SENSE, 8'h00);
        wr(REG_ENABLE, 8'h01);
        @(posedge clock) io_clk_active <= 1'b0;
        pins(3'h6, pcv);
        check(32'({wake_request, ext_irq_request}), 32'h8);
        pins(3'h7, pcv);
        @(posedge clock) io_clk_active <= 1'b1;
        settle;
        check(32'(ext_irq_request), 32'h0);
        // Each group: masked pin ignored, unmasked pin raises its own group
        for (int g = 0; g < 4; g++) begin
            wr(REG_PC_MASK0 + 4'(g), 8'h80);
            wr(REG_PC_CONTROL, 8'(1 << g));
            rd(REG_PC_MASK0 + 4'(g), 8'h80);
            pcv[8 * g] = ~pcv[8 * g];
            pins(3'h7, pcv);
            settle;
            check(32'(pin_change_group_request), 32'h0);
            pcv[8 * g + 7] = ~pcv[8 * g + 7];
            pins(3'h7, pcv);
            settle;
            check(32'(pin_change_group_request), 32'(1 << g));
            rd(REG_PC_FLAG, 8'(1 << g));
            @(posedge clock) global_int_enable <= 1'b0;
            @(negedge clock);
            check(32'(pin_change_group_request), 32'h0);
            @(posedge clock) global_int_enable <= 1'b1;
            wr(REG_PC_FLAG, 8'(1 << g));
            @(negedge clock);
            check(32'(pin_change_group_request), 32'h0);
        end
        // Change during sleep that reverts raises nothing; one that stays raises on restart
        @(posedge clock) io_clk_active <= 1'b0;
        pcv[31] = ~pcv[31];
        pins(3'h7, pcv);
        check(32'(wake_request), 32'h1);
        pcv[31] = ~pcv[31];
        pins(3'h7, pcv);
        @(posedge clock) io_clk_active <= 1'b1;
        settle;
        settle;
        check(32'(pin_change_group_request), 32'h0);
        @(posedge clock) io_clk_active <= 1'b0;
        pcv[31] = ~pcv[31];
        pins(3'h7, pcv);
        check(32'(pin_change_group_request), 32'h0);
        @(posedge clock) io_clk_active <= 1'b1;
        settle;
        settle;
        check(32'(pin_change_group_request), 32'h8);
        @(posedge clock) pin_change_ack <= 4'h8;
        @(posedge clock) pin_change_ack <= 4'h0;
        @(negedge clock);
        check(32'(pin_change_group_request), 32'h0);
        // Second reset in mid-run clears the group enables
        @(posedge clock) rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(REG_PC_CONTROL, 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
